//--- bench/ssp_peer.sv
`timescale 1ns/1ps
`default_nettype none

// off-chip slave for spi modes, pulse and message formats
module ssp_peer (
  input wire logic sclk,
  input wire logic fss,
  input wire logic mosi,
  input wire logic [1:0] fmt,
  input wire logic pha,
  input wire logic [3:0] size,
  input wire logic [15:0] reply,
  output logic miso,
  output logic [15:0] got
);
  int en;
  int k;
  logic arm;

  // quiet line until a frame opens
  initial begin
    miso = 1'b0;
    got = 16'h0000;
    arm = 1'b0;
  end

  // select low opens a frame; phase 0 shows the msb at once
  always @(negedge fss) if (fmt != 2'h1) begin
    en = 0;
    k = size;
    got = 16'h0000;
    if (!pha && fmt == 2'h0) miso = reply[size];
  end

  // released line flips so a stale bit never reads as valid
  always @(posedge fss) if (fmt != 2'h1) miso = ~miso;

  // edges counted only while selected
  always @(sclk) if (!fss && fmt != 2'h1) begin
    en++;
    if (fmt == 2'h2) begin
      if (en % 2 == 1 && en < 17) got = {got[14:0], mosi};
      else if (en % 2 == 0 && en >= 18 && k >= 0) begin
        miso = reply[k];
        k--;
      end
    end else if ((en % 2 == 1) != pha) begin
      got = {got[14:0], mosi};
    end else begin
      if (!pha) k--;
      if (k >= 0) miso = reply[k];
      if (pha) k--;
    end
  end

  always @(posedge sclk) if (fmt == 2'h1) begin
    #1;
    if (fss) begin
      arm = 1'b1;
      k = size;
      en = 0;
    end else if (arm && k >= 0) begin
      miso = reply[k];
      k--;
    end
  end

  always @(negedge sclk) if (fmt == 2'h1 && arm && !fss) begin
    got = {got[14:0], mosi};
    en++;
    if (en > size) arm = 1'b0;
    if (!arm) miso = ~miso;
  end
endmodule : ssp_peer

`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import ssp_pkg::*;
  logic clk, rst_n, enable, master_mode, pol, pha, loopback, data_write, data_read;
  logic dma_tx_enable, dma_rx_enable, timeout_clear, overrun_clear, rd_seen, sclk_q;
  logic ext_sclk, ext_fss;
  logic [1:0] fmt;
  logic [3:0] size, sz, e, interrupt_mask, raw_status, masked_status;
  logic [7:0] prescale, rate;
  logic [15:0] write_data, read_data, reply, got, w, r, mk;
  logic tx_full, rx_empty, tx_irq, rx_irq, to_irq, ov_irq, comb_irq;
  logic dma_tx_req, dma_rx_req, busy, sclk, sclk_oe_n, fss, fss_oe_n, miso, mosi, mosi_oe_n;
  int fail_count, checks, gap, half;
  logic [15:0] exp_q[$];
  logic [15:0] words[8];
  // an external master owns the pins while the port is a slave
  wire sclk_pin = sclk_oe_n ? ext_sclk : sclk;
  wire fss_pin = fss_oe_n ? ext_fss : fss;

  ssp_top uut (.clk, .rst_n, .enable, .master_mode, .frame_format(fmt),
    .clock_polarity_setting(pol), .clock_phase_setting(pha), .data_size(size), .loopback,
    .prescale_divisor(prescale), .clock_rate_field(rate), .interrupt_mask, .dma_tx_enable,
    .dma_rx_enable, .data_write, .write_data, .data_read, .read_data, .tx_full, .rx_empty,
    .timeout_clear, .overrun_clear, .raw_status, .masked_status, .tx_service_irq(tx_irq),
    .rx_service_irq(rx_irq), .timeout_irq(to_irq), .overrun_irq(ov_irq),
    .combined_irq(comb_irq), .dma_tx_req, .dma_rx_req, .busy, .serial_clock_line_in(sclk_pin),
    .serial_clock_line_out(sclk), .serial_clock_line_oe_n(sclk_oe_n),
    .frame_select_line_in(fss_pin), .frame_select_line_out(fss),
    .frame_select_line_oe_n(fss_oe_n), .serial_receive_line(miso),
    .serial_transmit_line(mosi), .serial_transmit_line_oe_n(mosi_oe_n));

  ssp_peer peer (.sclk(sclk), .fss(fss), .mosi(mosi), .fmt(fmt), .pha(pha), .size(size),
    .reply(reply), .miso(miso), .got(got));

  // free-running system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    checks++;
    if (seen !== expv) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  // read answers are matched with the oldest note
  always @(posedge clk) begin
    if (rd_seen) check(read_data, exp_q.pop_front());
    rd_seen = data_read && rx_empty === 1'b0;
  end

  // spi clock half periods follow the divider setting
  always @(posedge clk) begin
    if (fss !== 1'b0 || fmt != FMT_SPI) gap = -1;
    else if (sclk != sclk_q) begin
      if (gap >= 0) check(16'(gap), 16'(half));
      gap = 1;
    end else if (gap >= 0) gap++;
    sclk_q = sclk;
  end

  // a gap of eight quiet cycles marks the end of a burst
  task automatic idle_wait;
    int quiet;
    quiet = 0;
    for (int i = 0; i < 4000 && quiet < 8; i++) begin
      @(posedge clk);
      quiet = busy ? 0 : quiet + 1;
    end
  endtask : idle_wait

  task automatic run(input logic [3:0] cf, input logic [3:0] n, input logic [15:0] wd, rp);
    {fmt, pol, pha} <= cf;
    size <= n;
    reply <= rp;
    @(posedge clk);
    data_write <= 1'b1;
    write_data <= wd;
    @(posedge clk);
    data_write <= 1'b0;
    idle_wait();
  endtask : run

  task automatic pull(input logic [15:0] ev);
    exp_q.push_back(ev);
    data_read <= 1'b1;
    @(posedge clk);
    data_read <= 1'b0;
    @(posedge clk);
  endtask : pull

  // watchdog far beyond the expected few thousand cycles
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    summarize();
  end

  initial begin
    void'($urandom(98554));
    {rst_n, enable, master_mode, pol, pha, loopback, data_write, data_read} = 8'h60;
    {dma_tx_enable, dma_rx_enable, timeout_clear, overrun_clear} = 4'hC;
    {fmt, size, interrupt_mask, prescale, rate} = {FMT_SPI, 8'hF0, 16'h0202};
    {write_data, reply, half, rd_seen} = '0;
    {ext_sclk, ext_fss} = 2'b01;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    check(16'(raw_status), 16'h0001);
    check(16'({rx_empty, busy, sclk_oe_n, dma_tx_req, comb_irq}), 16'h0012);
    for (int m = 0; m < 4; m++) begin
      sz = 4'($urandom_range(15, 3));
      w = 16'($urandom);
      r = 16'($urandom);
      mk = 16'hFFFF >> (4'hF - sz);
      prescale <= 8'(2 + 2 * (m % 3));
      rate <= 8'(2 - m % 3);
      half = (1 + m % 3) * (3 - m % 3);
      run({FMT_SPI, 2'(m)}, sz, w, r);
      check(got & mk, w & mk);
      check(16'(sclk), 16'(pol));
      pull(r & mk);
    end
    $display("spi modes done");
    for (int m = 0; m < 2; m++) begin
      sz = 4'($urandom_range(15, 3));
      w = 16'($urandom);
      r = 16'($urandom);
      mk = 16'hFFFF >> (4'hF - sz);
      run({m ? FMT_MSG : FMT_PULSE, 2'b00}, sz, w, r);
      check(got & (m ? 16'h00FF : mk), w & (m ? 16'h00FF : mk));
      check(16'(sclk), 16'h0000);
      pull(r & mk);
    end
    $display("pulse and message done");
    {fmt, enable, loopback} <= {FMT_SPI, 2'b01};
    size <= 4'hF;
    for (int i = 0; i < 9; i++) begin
      if (i < 8) words[i] = 16'($urandom);
      data_write <= 1'b1;
      write_data <= (i < 8) ? words[i] : 16'hFFFF;
      @(posedge clk);
    end
    data_write <= 1'b0;
    @(posedge clk);
    check(16'({tx_full, busy, dma_tx_req}), 16'h0004);
    enable <= 1'b1;
    idle_wait();
    run({FMT_SPI, 2'b00}, 4'hF, 16'h1234, 16'h0000);
    check(16'({raw_status, dma_rx_req}), 16'h0017);
    for (int i = 0; i < 4; i++) begin
      interrupt_mask <= 4'(1 << i);
      repeat (2) @(posedge clk);
      e = 4'hB & 4'(1 << i);
      check(16'({masked_status, ov_irq, to_irq, rx_irq, tx_irq, comb_irq}), 16'({e, e, |e}));
    end
    repeat (200) @(posedge clk);
    check(16'(raw_status), 16'h000F);
    {timeout_clear, overrun_clear} <= 2'b11;
    @(posedge clk);
    {timeout_clear, overrun_clear} <= 2'b00;
    @(posedge clk);
    check(16'(raw_status[3:2]), 16'h0000);
    for (int i = 0; i < 8; i++) pull(words[i]);
    check(16'({rx_empty, dma_rx_req}), 16'h0002);
    $display("loopback and status done");
    master_mode <= 1'b0;
    repeat (2) @(posedge clk);
    check(16'({sclk_oe_n, fss_oe_n}), 16'h0003);
    $display("pin direction done");
    // external master at one sixteenth of the system clock
    // empty fifo: fifteen writes so far, words[1] is the eighth most recent
    ext_fss <= 1'b0;
    repeat (8) @(posedge clk);
    for (int b = 15; b >= 0; b--) begin
      ext_sclk <= 1'b1;
      repeat (8) @(posedge clk);
      check(16'({mosi_oe_n, mosi}), 16'({1'b0, words[1][b]}));
      ext_sclk <= 1'b0;
      // frame rises soon after the last edge so no second frame opens
      repeat (b > 0 ? 8 : 2) @(posedge clk);
    end
    ext_fss <= 1'b1;
    repeat (4) @(posedge clk);
    check(16'({mosi_oe_n, busy}), 16'h0002);
    pull(words[1]);
    $display("slave resend done");
    summarize();
  end
endmodule : tb_top

`default_nettype wire

//--- hw/ssp_pkg.sv
package ssp_pkg;
  // fifo geometry
  localparam int SSP_WIDTH = 16;
  localparam int SSP_DEPTH = 8;
  localparam int SSP_PTR_W = 3;
  localparam logic [3:0] FIFO_FULL_COUNT = 4'h8;
  localparam logic [3:0] FIFO_EMPTY_COUNT = 4'h0;
  localparam logic [SSP_WIDTH-1:0] ZERO_WORD = 16'h0000;
  // frame formats
  localparam logic [1:0] FMT_SPI = 2'h0;
  localparam logic [1:0] FMT_PULSE = 2'h1;
  localparam logic [1:0] FMT_MSG = 2'h2;
  // size field holds bits minus one; 4-bit frames are the least
  localparam logic [3:0] SIZE_MIN = 4'h3;
  // control message bits plus one wait bit
  localparam logic [4:0] MSG_LEAD_BITS = 5'h09;
  // first edge that captures reply data in message format
  localparam logic [5:0] MSG_FIRST_CAP_EDGE = 6'h13;
  // frame pulse takes one serial clock period, two edges
  localparam logic [5:0] PULSE_PRE_EDGES = 6'h02;
  localparam logic [5:0] EDGE_RESET = 6'h00;
  localparam logic [5:0] EDGE_FIRST = 6'h01;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  localparam logic [6:0] PRESCALE_HALF_MIN = 7'h01;
  // service levels and timeout in half serial periods
  localparam logic [3:0] TX_SERVICE_LEVEL = 4'h4;
  localparam logic [3:0] RX_SERVICE_LEVEL = 4'h4;
  localparam logic [6:0] RX_TIMEOUT_TICKS = 7'h40;
  localparam logic [6:0] TIMEOUT_RESET = 7'h00;
  // status bit positions
  localparam int ST_TXS = 0;
  localparam int ST_RXS = 1;
  localparam int ST_RTO = 2;
  localparam int ST_ROR = 3;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_XFER = 2'b10,
    ST_TAIL = 2'b11
  } ssp_state_type;
endpackage : ssp_pkg

//--- hw/ssp_top.sv
// Functional notes
// - master drives clock and frame; slave follows an external master
// - separate transmit and receive fifos, sixteen bits by eight entries
// - frame length programmable from four to sixteen bits
// - loopback returns transmitted serial data to the receive path
// - serial clock is system clock over even prescale times clock rate plus one
// - data write pushes transmit fifo; data read pops oldest receive word
// - slave with empty fifo resends eighth most recent word, or zero early on
// - interrupt or dma request possible when transmit fifo empties
// - received bits gather in a shift register then load the receive fifo
// - four sources: tx service, rx service, rx timeout, rx overrun, ORed
// - each source has a mask bit; one enables it
// - per-source outputs plus combined; raw and masked status readable
// - every frame is sent most significant bit first
// - serial clock idles inactive, toggles only during transfers
// - idle clock with data in receive fifo flags timeout after a period
// - spi and message formats hold frame low for the whole frame
// - pulse format raises frame one clock period from a rising edge
// - pulse format drives data on rising edge, samples on falling
// - message format sends eight control bits, then receives a 4-16 bit reply
// - fifos serve dma, with request enables per direction
// - enabled master with transmit data starts spi frame by lowering frame
// - spi polarity picks idle clock level; phase picks capture edge
`timescale 1ns/1ps
`default_nettype none

module ssp_fifo import ssp_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic [SSP_WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [SSP_WIDTH-1:0] head,
  output logic [SSP_WIDTH-1:0] oldest,
  output logic [SSP_PTR_W:0] count
);
  logic [SSP_WIDTH-1:0] mem [SSP_DEPTH];
  logic [SSP_PTR_W-1:0] wr_ptr;
  logic [SSP_PTR_W-1:0] rd_ptr;
  logic do_push;
  logic do_pop;

  // a push to a full fifo or a pop from an empty one is dropped
  assign do_push = push && (count != FIFO_FULL_COUNT);
  assign do_pop = pop && (count != FIFO_EMPTY_COUNT);
  assign head = mem[rd_ptr];
  // slot about to be overwritten holds the eighth most recent write
  assign oldest = mem[wr_ptr];

  // pointers wrap on their own at depth eight
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= FIFO_EMPTY_COUNT;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 3'h1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 3'h1;
      end
      count <= count + {3'h0, do_push} - {3'h0, do_pop};
    end
  end

  // storage needs no reset; slots are never used before they have been written
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data;
    end
  end
endmodule : ssp_fifo

module ssp_top import ssp_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic master_mode,
  input wire logic [1:0] frame_format,
  input wire logic clock_polarity_setting,
  input wire logic clock_phase_setting,
  input wire logic [3:0] data_size,
  input wire logic loopback,
  input wire logic [7:0] prescale_divisor,
  input wire logic [7:0] clock_rate_field,
  input wire logic [3:0] interrupt_mask,
  input wire logic dma_tx_enable,
  input wire logic dma_rx_enable,
  input wire logic data_write,
  input wire logic [15:0] write_data,
  input wire logic data_read,
  output logic [15:0] read_data,
  output logic tx_full,
  output logic rx_empty,
  input wire logic timeout_clear,
  input wire logic overrun_clear,
  output logic [3:0] raw_status,
  output logic [3:0] masked_status,
  output logic tx_service_irq,
  output logic rx_service_irq,
  output logic timeout_irq,
  output logic overrun_irq,
  output logic combined_irq,
  output logic dma_tx_req,
  output logic dma_rx_req,
  output logic busy,
  input wire logic serial_clock_line_in,
  output logic serial_clock_line_out,
  output logic serial_clock_line_oe_n,
  input wire logic frame_select_line_in,
  output logic frame_select_line_out,
  output logic frame_select_line_oe_n,
  input wire logic serial_receive_line,
  output logic serial_transmit_line,
  output logic serial_transmit_line_oe_n
);
  logic [1:0] rst_sync;
  logic rst_s_n;
  logic [2:0] sclk_sync;
  logic [1:0] fss_sync;
  logic [1:0] rx_sync;
  ssp_state_type state;
  logic cpol_eff, sph_eff, cap_raw, cap, shift, tick, edge_hit;
  logic m_start, s_start, start, abort, rx_push, tx_pop, rxd, hist_ok;
  logic to_flag, ovr_flag;
  logic [3:0] size_eff, top, tx_count, rx_count, wr_total;
  logic [4:0] nbits;
  logic [5:0] pre, total, edge_cnt, e_nx, d_nx;
  logic [15:0] half, div_cnt, tx_shift, rx_shift, tx_head, tx_oldest, rx_head, load_word;
  logic [6:0] to_cnt;
  logic sclk_q;

  // reset enters asynchronously, released through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_s_n = rst_sync[1];

  // pin synchronisers; bit 2 of the clock chain is only an edge history
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      sclk_sync <= 3'h0;
      fss_sync <= 2'h3;
      rx_sync <= 2'h0;
    end else begin
      sclk_sync <= {sclk_sync[1:0], serial_clock_line_in};
      fss_sync <= {fss_sync[0], frame_select_line_in};
      rx_sync <= {rx_sync[0], serial_receive_line};
    end
  end

  // frame geometry from the format and size controls
  always_comb begin
    cpol_eff = (frame_format == FMT_SPI) ? clock_polarity_setting : 1'b0;
    // pulse format: rising drive, falling sample
    sph_eff = (frame_format == FMT_SPI) ? clock_phase_setting : (frame_format == FMT_PULSE);
    // size clamps to four bits least
    size_eff = (data_size < SIZE_MIN) ? SIZE_MIN : data_size;
    // control bits and wait bit ahead of the reply
    nbits = ((frame_format == FMT_MSG) ? MSG_LEAD_BITS : 5'h00) + {1'b0, size_eff} + 5'h01;
    pre = (frame_format == FMT_PULSE) ? PULSE_PRE_EDGES : EDGE_RESET;
    total = {nbits, 1'b0} + pre;
    top = (frame_format == FMT_MSG) ? 4'h7 : size_eff;
    e_nx = edge_cnt + EDGE_FIRST;
    d_nx = e_nx - pre;
    cap_raw = (e_nx > pre) && (d_nx[0] != sph_eff);
    // incoming data ignored during the control message
    cap = cap_raw && ((frame_format != FMT_MSG) || (d_nx >= MSG_FIRST_CAP_EDGE));
    shift = (e_nx > pre) && (d_nx > EDGE_FIRST) && !cap_raw;
  end

  // half period is prescale over two times rate plus one
  assign half = 16'((prescale_divisor[7:1] < PRESCALE_HALF_MIN) ? PRESCALE_HALF_MIN
                    : prescale_divisor[7:1]) * (16'(clock_rate_field) + 16'h0001);
  assign tick = (div_cnt == half - 16'h0001);

  // divider restarts at each frame so the first half period is whole
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      div_cnt <= DIV_RESET;
    end else if (tick || start) begin
      div_cnt <= DIV_RESET;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  // enabled master with data starts a frame
  assign m_start = enable && master_mode && (state == ST_IDLE) && (tx_count != FIFO_EMPTY_COUNT);
  // slave starts when the external frame signal announces one
  assign s_start = enable && !master_mode && (state == ST_IDLE)
                   && ((frame_format == FMT_PULSE) ? fss_sync[1] : !fss_sync[1]);
  assign start = m_start || s_start;
  assign abort = !master_mode && (frame_format != FMT_PULSE) && fss_sync[1];
  assign edge_hit = (state == ST_XFER) && (master_mode ? tick : (sclk_sync[2] ^ sclk_sync[1]));
  assign rx_push = (state == ST_TAIL) && (!master_mode || tick);
  assign tx_pop = start && (tx_count != FIFO_EMPTY_COUNT);

  // frame sequencer; a slave skips the lead half period
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (m_start) begin
            state <= ST_LEAD;
          end else if (s_start) begin
            state <= ST_XFER;
          end
        end
        ST_LEAD: begin
          if (tick) begin
            state <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (abort) begin
            state <= ST_IDLE;
          end else if (edge_hit && (e_nx == total)) begin
            state <= ST_TAIL;
          end
        end
        ST_TAIL: begin
          if (!master_mode || tick) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // edge count; a pulse-format slave has already seen the first rising edge
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      edge_cnt <= EDGE_RESET;
    end else if (start) begin
      edge_cnt <= (s_start && (frame_format == FMT_PULSE)) ? EDGE_FIRST : EDGE_RESET;
    end else if (edge_hit) begin
      edge_cnt <= e_nx;
    end
  end

  // clock sits at its idle level outside frames
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      sclk_q <= 1'b0;
    end else if (state == ST_IDLE) begin
      sclk_q <= cpol_eff;
    end else if (edge_hit && master_mode) begin
      sclk_q <= ~sclk_q;
    end
  end

  // empty slave resends the eighth most recent word, zero before eight writes
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      wr_total <= 4'h0;
    end else if (data_write && !tx_full && !hist_ok) begin
      wr_total <= wr_total + 4'h1;
    end
  end
  assign hist_ok = (wr_total == FIFO_FULL_COUNT);
  assign load_word = (tx_count != FIFO_EMPTY_COUNT) ? tx_head : (hist_ok ? tx_oldest : ZERO_WORD);

  // msb first out of the transmit shifter
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      tx_shift <= ZERO_WORD;
    end else if (start) begin
      tx_shift <= load_word;
    end else if (edge_hit && shift) begin
      tx_shift <= {tx_shift[14:0], 1'b0};
    end
  end

  // loopback feeds our own transmit bit back
  assign rxd = loopback ? serial_transmit_line : rx_sync[1];
  // receive shifter, loaded to the fifo at frame end
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      rx_shift <= ZERO_WORD;
    end else if (start) begin
      rx_shift <= ZERO_WORD;
    end else if (edge_hit && cap) begin
      rx_shift <= {rx_shift[14:0], rxd};
    end
  end

  ssp_fifo u_tx_fifo (
    .clk(clk),
    .rst_n(rst_s_n),
    .push(data_write),
    .push_data(write_data),
    .pop(tx_pop),
    .head(tx_head),
    .oldest(tx_oldest),
    .count(tx_count)
  );
  ssp_fifo u_rx_fifo (
    .clk(clk),
    .rst_n(rst_s_n),
    .push(rx_push),
    .push_data(rx_shift),
    .pop(data_read),
    .head(rx_head),
    .oldest(),
    .count(rx_count)
  );
  assign tx_full = (tx_count == FIFO_FULL_COUNT);
  assign rx_empty = (rx_count == FIFO_EMPTY_COUNT);

  // read pops the oldest word into the data register
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      read_data <= ZERO_WORD;
    end else if (data_read && !rx_empty) begin
      read_data <= rx_head;
    end
  end

  // timeout counts half periods while idle with unread data
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      to_cnt <= TIMEOUT_RESET;
    end else if ((state != ST_IDLE) || rx_empty) begin
      to_cnt <= TIMEOUT_RESET;
    end else if (tick && (to_cnt != RX_TIMEOUT_TICKS)) begin
      to_cnt <= to_cnt + 7'h01;
    end
  end

  // sticky flags; a set in the clearing cycle wins
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      to_flag <= 1'b0;
      ovr_flag <= 1'b0;
    end else begin
      to_flag <= (tick && (to_cnt == RX_TIMEOUT_TICKS - 7'h01) && (state == ST_IDLE) && !rx_empty)
                 || (to_flag && !timeout_clear);
      ovr_flag <= (rx_push && (rx_count == FIFO_FULL_COUNT)) || (ovr_flag && !overrun_clear);
    end
  end

  // tx service covers the empty fifo
  always_comb begin
    raw_status = 4'h0;
    raw_status[ST_TXS] = (tx_count <= TX_SERVICE_LEVEL);
    raw_status[ST_RXS] = (rx_count >= RX_SERVICE_LEVEL);
    raw_status[ST_RTO] = to_flag;
    raw_status[ST_ROR] = ovr_flag;
  end
  assign masked_status = raw_status & interrupt_mask;
  assign tx_service_irq = masked_status[ST_TXS];
  assign rx_service_irq = masked_status[ST_RXS];
  assign timeout_irq = masked_status[ST_RTO];
  assign overrun_irq = masked_status[ST_ROR];
  assign combined_irq = |masked_status;
  assign dma_tx_req = dma_tx_enable && !tx_full;
  assign dma_rx_req = dma_rx_enable && !rx_empty;
  assign busy = (state != ST_IDLE);

  // low for the whole frame; pulse across edges one and two
  assign frame_select_line_out = (frame_format == FMT_PULSE)
      ? ((state == ST_XFER) && ((edge_cnt == EDGE_FIRST) || (edge_cnt == PULSE_PRE_EDGES)))
      : (state == ST_IDLE);
  assign serial_clock_line_out = sclk_q;
  assign serial_clock_line_oe_n = !master_mode;
  assign frame_select_line_oe_n = !master_mode;
  // line held low when idle; pulse format and slaves release it
  assign serial_transmit_line = (state == ST_IDLE) ? 1'b0 : tx_shift[top];
  assign serial_transmit_line_oe_n = (state == ST_IDLE)
      && ((frame_format == FMT_PULSE) || !master_mode);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_s_n);

  property p_idle_clk;
    // a polarity change while idle reaches the flop one cycle later
    state == ST_IDLE && $stable(cpol_eff) |-> serial_clock_line_out == cpol_eff;
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("clock not idle");
  property p_frame_low;
    master_mode && (frame_format != FMT_PULSE) && (state != ST_IDLE) |-> !frame_select_line_out;
  endproperty
  a_frame_low: assert property (p_frame_low) else $error("frame high mid frame");
  property p_pulse;
    $rose(frame_select_line_out) && master_mode && (frame_format == FMT_PULSE)
      |-> $rose(serial_clock_line_out)
      ##1 frame_select_line_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("frame pulse misplaced");
  property p_disabled;
    state == ST_IDLE && !enable |=> state == ST_IDLE;
  endproperty
  a_disabled: assert property (p_disabled) else $error("start while disabled");
  property p_push;
    data_write && !tx_full && !tx_pop |=> tx_count == $past(tx_count) + 4'h1;
  endproperty
  a_push: assert property (p_push) else $error("write not queued");
  property p_pop;
    data_read && !rx_empty |=> read_data == $past(rx_head) && rx_count < FIFO_FULL_COUNT;
  endproperty
  a_pop: assert property (p_pop) else $error("read word wrong");
  property p_msb;
    m_start |=> serial_transmit_line == $past(tx_head[top]);
  endproperty
  a_msb: assert property (p_msb) else $error("msb not first");
  property p_tx_irq;
    tx_count == FIFO_EMPTY_COUNT && interrupt_mask[ST_TXS] |-> combined_irq && tx_service_irq;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("empty fifo no irq");
  property p_ovr;
    rx_push && rx_count == FIFO_FULL_COUNT |=> raw_status[ST_ROR] [*2];
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun lost");
  property p_depth;
    tx_count <= FIFO_FULL_COUNT && rx_count <= FIFO_FULL_COUNT;
  endproperty
  a_depth: assert property (p_depth) else $error("fifo beyond depth");
endmodule : ssp_top

`default_nettype wire
